// ---- inc/spe_pkg.sv ----
package spe_pkg;

    localparam int BYTE_W = 8;

    // Character set of the command line
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [7:0] CH_QUERY = 8'h3F;
    localparam logic [7:0] CH_BANG = 8'h21;
    localparam logic [7:0] CH_GET = 8'h47;
    localparam logic [7:0] CH_SET = 8'h53;
    localparam logic [7:0] CH_SEMI = 8'h3B;
    localparam logic [7:0] CH_0 = 8'h30;
    localparam logic [7:0] CH_1 = 8'h31;

    // Two-letter command codes, first letter in the upper byte
    localparam logic [15:0] PRIVACY_MODE_CMD = 16'h4D4D;
    localparam logic [15:0] PRIVACY_STRING_CMD = 16'h4D59;
    localparam logic [15:0] COLD_BOOT_WARN_CMD = 16'h4543;
    localparam logic [15:0] WARM_BOOT_WARN_CMD = 16'h4557;
    localparam logic [15:0] AUTH_FAIL_WARN_CMD = 16'h4541;
    localparam logic [15:0] IP_CHANGE_WARN_CMD = 16'h4549;
    localparam logic [15:0] PASSWORD_CHANGE_WARN_CMD = 16'h4550;
    localparam logic [15:0] CARRIER_DETECT_WARN_CMD = 16'h4544;

    // Warning events, index 0 in the low slot
    localparam int NUM_EVENTS = 6;
    localparam logic [NUM_EVENTS*16-1:0] WARN_CODES = {CARRIER_DETECT_WARN_CMD, PASSWORD_CHANGE_WARN_CMD,
        IP_CHANGE_WARN_CMD, AUTH_FAIL_WARN_CMD, WARM_BOOT_WARN_CMD, COLD_BOOT_WARN_CMD};
    localparam logic [NUM_EVENTS-1:0] TRAP_CAPABLE = 6'h27;
    localparam logic [NUM_EVENTS-1:0] WARN_RESET = 6'h00;

    // Privacy mode index
    localparam logic [1:0] PRIV_DISABLE = 2'h0;
    localparam logic [1:0] PRIV_DES = 2'h1;
    localparam logic [1:0] PRIV_AES = 2'h2;
    localparam logic [1:0] PRIV_RESET = PRIV_DISABLE;

    // Byte positions within a received line
    localparam int POS_LEAD = 0;
    localparam int POS_OP = 1;
    localparam int POS_CODE_HI = 2;
    localparam int POS_CODE_LO = 3;
    localparam int POS_INDEX = 4;
    localparam int POS_SEP = 5;
    localparam int POS_VALUE = 6;
    localparam int GET_LEN = 5;
    localparam int SET_DIGIT_LEN = 7;
    localparam int STR_SET_HEAD = 6;
    localparam int REPLY_HEAD = 5;

    // Register map, byte addresses
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_IRQ_STATUS = 5'h04;
    localparam logic [4:0] OFS_IRQ_MASK = 5'h08;
    localparam logic [4:0] OFS_PRIV_VIEW = 5'h0C;
    localparam logic [4:0] OFS_WARN_VIEW = 5'h10;
    localparam logic CTRL_ENABLE_RESET = 1'b1;
    localparam int IRQ_W = 3;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERROR = 1;
    localparam int IRQ_CHANGE = 2;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
    localparam int WARN_TRAP_POS = 8;

    typedef enum logic [1:0] {ST_COLLECT, ST_EXEC, ST_REPLY} spe_state_type;

endpackage

// ---- hw/spe_reset_sync.sv ----
`timescale 1ns/1ps
module spe_reset_sync (
    input wire logic clock,
    input wire logic reset_n,
    output logic rst_sync_n
);
    logic stage_q;

    // Assert at once, release on the second edge
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stage_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            stage_q <= 1'b1;
            rst_sync_n <= stage_q;
        end
    end
endmodule

// ---- hw/spe_csr.sv ----
`timescale 1ns/1ps
module spe_csr
    import spe_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    input wire logic [spe_pkg::IRQ_W-1:0] events,
    input wire logic [3:0] priv_view,
    input wire logic [spe_pkg::NUM_EVENTS-1:0] mail_view,
    input wire logic [spe_pkg::NUM_EVENTS-1:0] trap_view,
    output logic ctrl_enable_q
);
    logic [IRQ_W-1:0] status_q;
    logic [IRQ_W-1:0] mask_q;

    wire request = avs_read | avs_write;
    // Accept on the edge where waitrequest is seen low
    wire do_write = avs_write & ~avs_waitrequest;
    wire [31:0] lane_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire [31:0] wbits = avs_writedata & lane_mask;
    wire [IRQ_W-1:0] clear_bits = (do_write && avs_address == OFS_IRQ_STATUS) ? wbits[IRQ_W-1:0] : IRQ_RESET;
    // A new event beats a simultaneous clear
    wire [IRQ_W-1:0] status_d = (status_q & ~clear_bits) | events;
    wire [IRQ_W-1:0] mask_d = (do_write && avs_address == OFS_IRQ_MASK && avs_byteenable[0]) ?
        avs_writedata[IRQ_W-1:0] : mask_q;
    wire ctrl_d = (do_write && avs_address == OFS_CTRL && avs_byteenable[0]) ? avs_writedata[0] : ctrl_enable_q;
    wire [31:0] warn_word = {18'h0, trap_view, 2'h0, mail_view};
    // Unmapped offsets read zero, writes to them are dropped
    wire [31:0] read_mux =
        (avs_address == OFS_CTRL) ? {31'h0, ctrl_enable_q} :
        (avs_address == OFS_IRQ_STATUS) ? {29'h0, status_q} :
        (avs_address == OFS_IRQ_MASK) ? {29'h0, mask_q} :
        (avs_address == OFS_PRIV_VIEW) ? {28'h0, priv_view} :
        (avs_address == OFS_WARN_VIEW) ? warn_word : 32'h0;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
            status_q <= IRQ_RESET;
            mask_q <= IRQ_RESET;
            ctrl_enable_q <= CTRL_ENABLE_RESET;
            irq <= 1'b0;
        end else begin
            avs_waitrequest <= ~(request & avs_waitrequest);
            avs_readdata <= (avs_read & avs_waitrequest) ? read_mux : 32'h0;
            status_q <= status_d;
            mask_q <= mask_d;
            ctrl_enable_q <= ctrl_d;
            irq <= |(status_q & mask_q);
        end
    end
endmodule

// ---- hw/spe_cmd_interp.sv ----
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
// How it works
// - Privacy mode index is 0 disabled, 1 DES, 2 AES, in replies and sets.
// - Privacy mode query replies marker, opcode, code, success digit, mode index.
// - Successful set replies marker, echoed opcode and code, success digit, nothing more.
// - Privacy string commands carry user index; set stores string after semicolon.
// - Warning query takes target index, 0 mail, 1 trap.
// - Warning enable is 1 enabled, 0 disabled.
// - IP change and password change warnings have only the mail target.
// - Warning query replies header, success digit, then the requested enable.
// - Warm start event keeps separate mail and trap enables.
// - Authentication failure event keeps separate mail and trap enables.
// - Carrier detect event keeps separate mail and trap enables.
module spe_cmd_interp
    import spe_pkg::*;
#(
    parameter int STR_MAX = 16
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [spe_pkg::BYTE_W-1:0] rx_data,
    input wire logic rx_valid,
    output logic rx_ready,
    output logic [spe_pkg::BYTE_W-1:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq
);
    localparam int LINE_MAX = STR_SET_HEAD + STR_MAX;
    localparam int CW = $clog2(LINE_MAX + 1) + 1;
    localparam int SLW = $clog2(STR_MAX + 1);
    localparam int SIW = (STR_MAX > 1) ? $clog2(STR_MAX) : 1;
    localparam logic [CW-1:0] L_GET = CW'(GET_LEN);
    localparam logic [CW-1:0] L_SET_DIGIT = CW'(SET_DIGIT_LEN);
    localparam logic [CW-1:0] L_STR_HEAD = CW'(STR_SET_HEAD);
    localparam logic [CW-1:0] L_LINE_MAX = CW'(LINE_MAX);
    localparam logic [CW-1:0] L_REPLY_HEAD = CW'(REPLY_HEAD);

    logic rst_n;
    spe_state_type state_q;
    spe_state_type state_d;
    logic [7:0] line_q [LINE_MAX];
    logic [CW-1:0] len_q;
    logic overflow_q;
    logic [1:0] mode_q [2];
    logic [7:0] str_q [2][STR_MAX];
    logic [SLW-1:0] str_len_q [2];
    logic [NUM_EVENTS-1:0] mail_q;
    logic [NUM_EVENTS-1:0] trap_q;
    logic [7:0] status_ch_q;
    logic [7:0] param_q;
    logic kind_str_q;
    logic reply_user_q;
    logic [CW-1:0] reply_len_q;
    logic [CW-1:0] tx_idx_q;
    logic ctrl_enable;
    logic [IRQ_W-1:0] events;

    spe_reset_sync u_reset_sync (
        .clock(clock),
        .reset_n(reset_n),
        .rst_sync_n(rst_n)
    );

    // Receive side
    wire accept = rx_valid & rx_ready;
    wire is_term = rx_data == CH_CR;
    wire is_lf = rx_data == CH_LF;
    wire is_text = accept & ~is_term & ~is_lf;
    wire store = is_text & (len_q < L_LINE_MAX);
    wire overflow_hit = is_text & (len_q == L_LINE_MAX);
    // A bare terminator is skipped rather than answered
    wire blank_line = (len_q == '0) & ~overflow_q;
    wire line_done = accept & is_term & ~blank_line;

    // Field view of the captured line
    wire [7:0] op_b = line_q[POS_OP];
    wire [7:0] code_hi_b = line_q[POS_CODE_HI];
    wire [7:0] code_lo_b = line_q[POS_CODE_LO];
    wire [15:0] code_b = {code_hi_b, code_lo_b};
    wire [7:0] idx_b = line_q[POS_INDEX];
    wire [7:0] sep_b = line_q[POS_SEP];
    wire [7:0] val_b = line_q[POS_VALUE];

    wire head_ok = ~overflow_q & (len_q >= L_GET) & (line_q[POS_LEAD] == CH_QUERY);
    wire is_get = head_ok & (op_b == CH_GET) & (len_q == L_GET);
    wire is_set = head_ok & (op_b == CH_SET) & (sep_b == CH_SEMI);
    wire set_digit = is_set & (len_q == L_SET_DIGIT);
    wire set_str = is_set & (len_q >= L_STR_HEAD);

    wire user_ok = (idx_b == CH_0) | (idx_b == CH_1);
    wire user_sel = idx_b == CH_1;
    wire hit_mode = code_b == PRIVACY_MODE_CMD;
    wire hit_str = code_b == PRIVACY_STRING_CMD;
    wire [7:0] mode_top = CH_0 + {6'h0, PRIV_AES};
    wire mode_ok = (val_b >= CH_0) & (val_b <= mode_top);
    wire enable_ok = (val_b == CH_0) | (val_b == CH_1);

    logic [NUM_EVENTS-1:0] warn_hit;
    genvar e;
    generate
        for (e = 0; e < NUM_EVENTS; e++) begin : g_hit
            assign warn_hit[e] = code_b == WARN_CODES[e*16 +: 16];
        end
    endgenerate

    wire any_warn = |warn_hit;
    wire trap_ok = |(warn_hit & TRAP_CAPABLE);
    wire target_trap = idx_b == CH_1;
    wire target_ok = (idx_b == CH_0) | (target_trap & trap_ok);

    wire do_mode_get = is_get & hit_mode & user_ok;
    wire do_mode_set = set_digit & hit_mode & user_ok & mode_ok;
    wire do_str_get = is_get & hit_str & user_ok;
    wire do_str_set = set_str & hit_str & user_ok;
    wire do_warn_get = is_get & any_warn & target_ok;
    wire do_warn_set = set_digit & any_warn & target_ok & enable_ok;
    wire any_set = do_mode_set | do_str_set | do_warn_set;
    wire any_get = do_mode_get | do_str_get | do_warn_get;
    // Everything else is answered as an error and touches nothing
    wire cmd_ok = any_set | any_get;

    wire exec = state_q == ST_EXEC;
    wire [CW-1:0] str_len_wide = len_q - L_STR_HEAD;
    wire [SLW-1:0] new_str_len = str_len_wide[SLW-1:0];
    wire new_enable = val_b == CH_1;
    wire [1:0] new_mode = val_b[1:0];

    // Parameter digit of a query
    wire [1:0] cur_mode = mode_q[user_sel];
    wire cur_mail = |(warn_hit & mail_q);
    wire cur_trap = |(warn_hit & trap_q);
    wire cur_enable = target_trap ? cur_trap : cur_mail;
    wire [7:0] mode_digit = CH_0 + {6'h0, cur_mode};
    wire [7:0] enable_digit = cur_enable ? CH_1 : CH_0;
    wire [7:0] param_d = do_mode_get ? mode_digit : enable_digit;
    wire [CW-1:0] cur_str_len = CW'(str_len_q[user_sel]);

    // Reply length with the terminator counted
    wire [CW-1:0] len_plain = L_REPLY_HEAD + 1'b1;
    wire [CW-1:0] len_digit = L_REPLY_HEAD + 2'h2;
    wire [CW-1:0] len_string = L_REPLY_HEAD + cur_str_len + 1'b1;
    wire [CW-1:0] reply_len_d = ~cmd_ok ? len_plain :
        any_set ? len_plain :
        do_str_get ? len_string : len_digit;

    // Transmit byte selection
    wire [CW-1:0] str_pos = tx_idx_q - L_REPLY_HEAD;
    wire [7:0] str_byte = str_q[reply_user_q][str_pos[SIW-1:0]];
    wire [CW-1:0] last_idx = reply_len_q - 1'b1;
    wire [7:0] reply_byte =
        (tx_idx_q == last_idx) ? CH_CR :
        (tx_idx_q == CW'(0)) ? CH_BANG :
        (tx_idx_q == CW'(POS_OP)) ? op_b :
        (tx_idx_q == CW'(POS_CODE_HI)) ? code_hi_b :
        (tx_idx_q == CW'(POS_CODE_LO)) ? code_lo_b :
        (tx_idx_q == CW'(POS_INDEX)) ? status_ch_q :
        kind_str_q ? str_byte : param_q;

    wire in_reply = state_q == ST_REPLY;
    wire tx_free = ~tx_valid | tx_ready;
    wire reply_left = tx_idx_q < reply_len_q;
    wire tx_load = in_reply & tx_free & reply_left;
    wire tx_valid_d = tx_load | (tx_valid & ~tx_ready);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_COLLECT: begin
                if (line_done) begin
                    state_d = ST_EXEC;
                end
            end
            ST_EXEC: begin
                state_d = ST_REPLY;
            end
            ST_REPLY: begin
                if (tx_free && !reply_left) begin
                    state_d = ST_COLLECT;
                end
            end
        endcase
    end

    // Input stalls while a command runs or software has it disabled
    wire rx_ready_d = (state_d == ST_COLLECT) & ctrl_enable;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_COLLECT;
            rx_ready <= 1'b0;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            tx_idx_q <= '0;
        end else begin
            state_q <= state_d;
            rx_ready <= rx_ready_d;
            tx_valid <= tx_valid_d;
            if (tx_load) begin
                tx_data <= reply_byte;
            end
            tx_idx_q <= exec ? '0 : (tx_load ? tx_idx_q + 1'b1 : tx_idx_q);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            len_q <= '0;
            overflow_q <= 1'b0;
        end else if (exec) begin
            len_q <= '0;
            overflow_q <= 1'b0;
        end else begin
            len_q <= store ? len_q + 1'b1 : len_q;
            overflow_q <= overflow_q | overflow_hit;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            status_ch_q <= CH_0;
            param_q <= CH_0;
            kind_str_q <= 1'b0;
            reply_user_q <= 1'b0;
            reply_len_q <= '0;
        end else if (exec) begin
            status_ch_q <= cmd_ok ? CH_0 : CH_1;
            param_q <= param_d;
            kind_str_q <= do_str_get;
            reply_user_q <= user_sel;
            reply_len_q <= reply_len_d;
        end
    end

    genvar i;
    genvar u;
    generate
        for (i = 0; i < LINE_MAX; i++) begin : g_line
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    line_q[i] <= 8'h00;
                end else if (store && len_q == CW'(i)) begin
                    line_q[i] <= rx_data;
                end
            end
        end

        for (u = 0; u < 2; u++) begin : g_user
            wire pick = user_sel == 1'(u);

            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    mode_q[u] <= PRIV_RESET;
                    str_len_q[u] <= '0;
                end else if (exec) begin
                    if (do_mode_set && pick) begin
                        mode_q[u] <= new_mode;
                    end
                    if (do_str_set && pick) begin
                        str_len_q[u] <= new_str_len;
                    end
                end
            end

            for (i = 0; i < STR_MAX; i++) begin : g_char
                always_ff @(posedge clock or negedge rst_n) begin
                    if (!rst_n) begin
                        str_q[u][i] <= 8'h00;
                    end else if (exec && do_str_set && pick) begin
                        // Unused tail cleared so a shorter string leaves no trace
                        str_q[u][i] <= (CW'(i) < str_len_wide) ? line_q[STR_SET_HEAD + i] : 8'h00;
                    end
                end
            end
        end

        for (e = 0; e < NUM_EVENTS; e++) begin : g_warn
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    mail_q[e] <= WARN_RESET[e];
                    trap_q[e] <= WARN_RESET[e];
                end else if (exec && do_warn_set && warn_hit[e]) begin
                    // Only the addressed target moves
                    if (target_trap) begin
                        trap_q[e] <= new_enable;
                    end else begin
                        mail_q[e] <= new_enable;
                    end
                end
            end
        end
    endgenerate

    assign events[IRQ_DONE] = exec;
    assign events[IRQ_ERROR] = exec & ~cmd_ok;
    assign events[IRQ_CHANGE] = exec & any_set;

    spe_csr u_csr (
        .clock(clock),
        .rst_n(rst_n),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .irq(irq),
        .events(events),
        .priv_view({mode_q[1], mode_q[0]}),
        .mail_view(mail_q),
        .trap_view(trap_q),
        .ctrl_enable_q(ctrl_enable)
    );
endmodule

// ---- testbench/spe_cmd_interp_properties.sv ----
`timescale 1ns/1ps
module spe_cmd_interp_check #(
    parameter int STR_MAX = 16
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [spe_pkg::BYTE_W-1:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic [spe_pkg::BYTE_W-1:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    import spe_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    wire line_end = rx_valid && rx_ready && rx_data == CH_CR;
    wire body_byte = rx_valid && rx_ready && rx_data != CH_CR && rx_data != CH_LF;
    wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered in the next cycle");
    idle_data_a: assert property (avs_waitrequest |-> avs_readdata == 32'h0)
        else $error("read data not zero outside a transfer");
    unmapped_read_a: assert property (avs_read && !avs_waitrequest && avs_address > OFS_WARN_VIEW
        |-> avs_readdata == 32'h0)
        else $error("unmapped address read nonzero");
    view_width_a: assert property (avs_read && !avs_waitrequest && avs_address == OFS_PRIV_VIEW
        |-> avs_readdata[31:4] == 28'h0)
        else $error("privacy view has bits above the two modes");
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply byte dropped or changed while stalled");
    reply_busy_a: assert property (tx_valid |-> !rx_ready)
        else $error("receiver ready while a reply is pending");
    reply_lead_a: assert property (line_end && $past(body_byte) |-> ##[2:3] tx_valid && tx_data == CH_BANG)
        else $error("reply does not start with the marker in time");
    reply_end_a: assert property (tx_valid && tx_ready && tx_data == CH_CR |=> !tx_valid)
        else $error("bytes sent after the reply terminator");
endmodule

bind spe_cmd_interp spe_cmd_interp_check #(.STR_MAX(STR_MAX)) u_spe_cmd_interp_check (
    .clock(clock), .reset_n(reset_n), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest)
);

// ---- testbench/spe_host_model.sv ----
`timescale 1ns/1ps
module spe_host_model (
    input wire logic clock,
    input wire logic slow,
    output logic [spe_pkg::BYTE_W-1:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    input wire logic [spe_pkg::BYTE_W-1:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready
);
    import spe_pkg::*;
    initial begin
        rx_data = 8'hFF;
        rx_valid = 1'h0;
        tx_ready = 1'h1;
    end
    // Stalling sink forces the reply bytes to be held
    always @(posedge clock) begin
        tx_ready <= slow ? ~tx_ready : 1'h1;
    end
    // Index, separator and value order come from the caller's line text
    task automatic send(input string s);
        for (int i = 0; i <= s.len(); i++) begin
            rx_data <= (i == s.len()) ? CH_CR : s[i];
            rx_valid <= 1'h1;
            do @(posedge clock); while (rx_ready !== 1'h1);
        end
        rx_valid <= 1'h0;
        // Released line must not keep showing the last byte
        rx_data <= ~rx_data;
    endtask
    task automatic recv(output string s);
        s = "";
        do begin
            @(posedge clock);
            if (tx_valid === 1'h1 && tx_ready === 1'h1 && tx_data !== CH_CR) begin
                s = {s, string'(tx_data)};
            end
        end while (!(tx_valid === 1'h1 && tx_ready === 1'h1 && tx_data === CH_CR));
    endtask
endmodule

// ---- testbench/test_spe_cmd_interp.sv ----
`timescale 1ns/1ps
module test_spe_cmd_interp;
    import spe_pkg::*;
    localparam int STR_MAX = 4;
    logic clock = 1'h0;
    logic reset_n = 1'h0;
    logic slow = 1'h0;
    logic [7:0] rx_data, tx_data;
    logic rx_valid, rx_ready, tx_valid, tx_ready, avs_waitrequest, irq;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [4:0] avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] byteen = 4'hF;
    logic [31:0] avs_readdata, rd;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    string reply;
    string codes [4] = '{"C", "W", "A", "D"};
    spe_cmd_interp #(.STR_MAX(STR_MAX)) u_spe_cmd_interp (
        .clock(clock), .reset_n(reset_n), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(byteen), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq)
    );
    spe_host_model u_spe_host_model (
        .clock(clock), .slow(slow), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready)
    );
    initial begin
        forever #20 clock = ~clock;
    end
    task automatic test_done();
        $display("Checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            test_done();
        end
    end
    task automatic check(input string what, input string seen, input string exp);
        checks_done++;
        if (seen != exp) begin
            errors++;
            $display("BAD %s expected %s seen %s", what, exp, seen);
        end
    endtask
    task automatic cmd(input string c, input string exp);
        u_spe_host_model.send(c);
        u_spe_host_model.recv(reply);
        check(c, reply, exp);
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= ~w;
        do @(posedge clock); while (avs_waitrequest !== 1'h0);
        rd = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        @(posedge clock);
    endtask
    task automatic rcheck(input string what, input logic [4:0] a, input logic [31:0] exp);
        bus(1'h0, a, 32'h0);
        check(what, $sformatf("%h", rd), $sformatf("%h", exp));
    endtask
    initial begin
        repeat (12) @(posedge clock);
        reset_n <= 1'h1;
        repeat (3) @(posedge clock);
        rcheck("ctrl", OFS_CTRL, 32'h1);
        rcheck("irq mask", OFS_IRQ_MASK, 32'h0);
        rcheck("priv view", OFS_PRIV_VIEW, 32'h0);
        cmd("?GMM0", "!GMM00");
        cmd("?SMM0;1", "!SMM0");
        cmd("?SMM1;2", "!SMM0");
        cmd("?GMM0", "!GMM01");
        cmd("?GMM1", "!GMM02");
        cmd("?SMM0;3", "!SMM1");
        cmd("?SMM2;1", "!SMM1");
        cmd("?GMM0", "!GMM01");
        slow <= 1'h1;
        cmd("?SMY1;ab", "!SMY0");
        cmd("?GMY1", "!GMY0ab");
        cmd("?GMY0", "!GMY0");
        cmd("?SMY0;abcde", "!SMY1");
        cmd("?GMY0", "!GMY0");
        slow <= 1'h0;
        foreach (codes[i]) begin
            cmd({"?SE", codes[i], "1;1"}, {"!SE", codes[i], "0"});
            cmd({"?GE", codes[i], "1"}, {"!GE", codes[i], "01"});
            cmd({"?GE", codes[i], "0"}, {"!GE", codes[i], "00"});
        end
        cmd("?SEC0;2", "!SEC1");
        cmd("?SEI0;1", "!SEI0");
        cmd("?GEI0", "!GEI01");
        cmd("?SEP1;1", "!SEP1");
        cmd("?GEP1", "!GEP1");
        cmd("?GZZ0", "!GZZ1");
        rcheck("priv view", OFS_PRIV_VIEW, 32'h9);
        rcheck("warn view", OFS_WARN_VIEW, 32'h2708);
        rcheck("unmapped", 5'h14, 32'h0);
        rcheck("irq status", OFS_IRQ_STATUS, 32'h7);
        check("irq masked", $sformatf("%b", irq), "0");
        // Write with every lane off must leave the mask alone
        byteen <= 4'h0;
        bus(1'h1, OFS_IRQ_MASK, 32'h7);
        byteen <= 4'hF;
        rcheck("mask lanes off", OFS_IRQ_MASK, 32'h0);
        bus(1'h1, OFS_IRQ_MASK, 32'h2);
        repeat (2) @(posedge clock);
        check("irq raised", $sformatf("%b", irq), "1");
        bus(1'h1, OFS_IRQ_STATUS, 32'h2);
        repeat (2) @(posedge clock);
        check("irq cleared", $sformatf("%b", irq), "0");
        rcheck("irq status", OFS_IRQ_STATUS, 32'h5);
        bus(1'h1, OFS_CTRL, 32'h0);
        repeat (2) @(posedge clock);
        check("rx ready off", $sformatf("%b", rx_ready), "0");
        bus(1'h1, OFS_CTRL, 32'h1);
        cmd("?GEW1", "!GEW01");
        test_done();
    end
endmodule
